//--- pasb_defs.vh
// Offsets, page codes and reset values of the paged alarm status bank
`ifndef PASB_DEFS_VH
`define PASB_DEFS_VH
`define PASB_OFS_LIVE_A 8'h02
`define PASB_OFS_STICKY_A 8'h03
`define PASB_OFS_MASK_A 8'h04
`define PASB_OFS_LIVE_B 8'h06
`define PASB_OFS_STICKY_B 8'h07
`define PASB_OFS_MASK_B 8'h08
`define PASB_OFS_PAGE 8'hFF
`define PASB_OFS_WAKE 8'hE1
`define PASB_PAGE_MAIN 8'h00
`define PASB_PAGE_MON 8'h01
`define PASB_PAGE_INSYS 8'h02
`define PASB_PAGE_OUTSYS 8'h03
`define PASB_PAGE_PLLA 8'h0A
`define PASB_PAGE_PLLD 8'h0D
`define PASB_BIT_CRYSTAL 2
`define PASB_RST_PAGE 8'h00
`define PASB_RST_MASK 8'h00
`define PASB_RST_STICKY 8'h00
`endif

//--- pasb_notify.v
// One sticky notify register with its mask
`timescale 1ns/10ps
`default_nettype none
module pasb_notify #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clk_sys,
	input wire arst_n,
	// Live status and write access
	input wire [WIDTH-1:0] live,
	input wire sticky_wr,
	input wire mask_wr,
	input wire [WIDTH-1:0] wr_data,
	// Register contents
	output reg [WIDTH-1:0] sticky,
	output reg [WIDTH-1:0] mask
);
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mask <= {WIDTH{1'b0}};
		end else if (mask_wr) begin
			mask <= wr_data;
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sticky <= {WIDTH{1'b0}};
		end else begin
			// write one clears; masked set wins over clear
			sticky <= (sticky & ~(sticky_wr ? wr_data : {WIDTH{1'b0}})) | (live & mask);
		end
	end
endmodule
`default_nettype wire

//--- pasb_bank.v
// Paged alarm status bank: page select, live status, sticky notifies
`timescale 1ns/10ps
`default_nettype none
`include "pasb_defs.vh"
module pasb_bank #(
	parameter INPUTS = 4,
	parameter PLLS = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire arst_n,
	// Register access port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// Live status from the clock system
	input wire crystal_input_missing,
	input wire [INPUTS-1:0] input_loss,
	input wire [INPUTS-1:0] fine_drift_live,
	input wire [INPUTS-1:0] coarse_drift_live,
	input wire [PLLS-1:0] pll_lock_loss,
	input wire [PLLS-1:0] retention_mode,
	// Subsystem wake and page state
	output wire [6:0] slave_wake,
	output wire [7:0] current_page
);
	// Register state and next values
	reg [7:0] page_select;
	reg [7:0] next_page;
	reg [6:0] wake;
	reg [6:0] next_wake;
	reg [7:0] next_rdata;
	// Pin synchronisers
	reg s1;
	reg s2;
	reg [INPUTS-1:0] loss1;
	reg [INPUTS-1:0] loss2;
	reg [INPUTS-1:0] fine1;
	reg [INPUTS-1:0] fine2;
	reg [INPUTS-1:0] coarse1;
	reg [INPUTS-1:0] coarse2;
	reg [PLLS-1:0] lol1;
	reg [PLLS-1:0] lol2;
	reg [PLLS-1:0] ret1;
	reg [PLLS-1:0] ret2;

	// Status words
	reg [7:0] crystal_loss_live;
	wire [7:0] input_loss_live;
	wire [7:0] pll_lock_freeze_live;
	wire [7:0] input_drift_live;
	wire [7:0] crystal_loss_sticky;
	wire [7:0] crystal_mask;
	wire [7:0] input_loss_sticky;
	wire [7:0] input_mask;
	wire [7:0] pll_lock_freeze_sticky;
	wire [7:0] pll_mask;
	wire [7:0] input_drift_sticky;
	wire [7:0] drift_mask;
	// Page decode and write strobes
	wire on_main;
	wire on_mon;
	wire wr_page;
	wire wr_wake;
	wire wr_crystal_sticky;
	wire wr_crystal_mask;
	wire wr_pll_sticky;
	wire wr_pll_mask;
	wire wr_loss_sticky;
	wire wr_loss_mask;
	wire wr_drift_sticky;
	wire wr_drift_mask;

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		input wr;
		begin
			hit = wr && (addr == ofs);
		end
	endfunction

	// Read decode shared by the main and monitor pages
	function [7:0] page_word;
		input [7:0] addr;
		input [7:0] live_a;
		input [7:0] sticky_a;
		input [7:0] mask_a;
		input [7:0] live_b;
		input [7:0] sticky_b;
		input [7:0] mask_b;
		begin
			case (addr)
			`PASB_OFS_LIVE_A: page_word = live_a;
			`PASB_OFS_STICKY_A: page_word = sticky_a;
			`PASB_OFS_MASK_A: page_word = mask_a;
			`PASB_OFS_LIVE_B: page_word = live_b;
			`PASB_OFS_STICKY_B: page_word = sticky_b;
			`PASB_OFS_MASK_B: page_word = mask_b;
			default: page_word = 8'h00;
			endcase
		end
	endfunction

	// Pin inputs pass two flip-flops
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 1'h0;
			s2 <= 1'h0;
			loss1 <= {INPUTS{1'b0}};
			loss2 <= {INPUTS{1'b0}};
			fine1 <= {INPUTS{1'b0}};
			fine2 <= {INPUTS{1'b0}};
			coarse1 <= {INPUTS{1'b0}};
			coarse2 <= {INPUTS{1'b0}};
			lol1 <= {PLLS{1'b0}};
			lol2 <= {PLLS{1'b0}};
			ret1 <= {PLLS{1'b0}};
			ret2 <= {PLLS{1'b0}};
		end else begin
			s1 <= crystal_input_missing;
			s2 <= s1;
			loss1 <= input_loss;
			loss2 <= loss1;
			fine1 <= fine_drift_live;
			fine2 <= fine1;
			coarse1 <= coarse_drift_live;
			coarse2 <= coarse1;
			lol1 <= pll_lock_loss;
			lol2 <= lol1;
			ret1 <= retention_mode;
			ret2 <= ret1;
		end
	end

	// page switch held until next write to the page register
	always @* begin
		next_page = page_select;
		if (wr_page) begin
			next_page = reg_wdata;
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			page_select <= `PASB_RST_PAGE;
		end else begin
			page_select <= next_page;
		end
	end

	assign on_main = (page_select == `PASB_PAGE_MAIN);
	assign on_mon = (page_select == `PASB_PAGE_MON);
	assign current_page = page_select;

	assign wr_page = hit(reg_addr, `PASB_OFS_PAGE, reg_wr);
	assign wr_wake = on_main && hit(reg_addr, `PASB_OFS_WAKE, reg_wr);
	assign wr_crystal_sticky = on_main && hit(reg_addr, `PASB_OFS_STICKY_A, reg_wr);
	assign wr_crystal_mask = on_main && hit(reg_addr, `PASB_OFS_MASK_A, reg_wr);
	assign wr_pll_sticky = on_main && hit(reg_addr, `PASB_OFS_STICKY_B, reg_wr);
	assign wr_pll_mask = on_main && hit(reg_addr, `PASB_OFS_MASK_B, reg_wr);
	assign wr_loss_sticky = on_mon && hit(reg_addr, `PASB_OFS_STICKY_A, reg_wr);
	assign wr_loss_mask = on_mon && hit(reg_addr, `PASB_OFS_MASK_A, reg_wr);
	assign wr_drift_sticky = on_mon && hit(reg_addr, `PASB_OFS_STICKY_B, reg_wr);
	assign wr_drift_mask = on_mon && hit(reg_addr, `PASB_OFS_MASK_B, reg_wr);

	// slaves stay down until host writes the wake register on the main page
	always @* begin
		next_wake = wake;
		if (wr_wake) begin
			next_wake = reg_wdata[6:0];
		end
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake <= 7'h00;
		end else begin
			wake <= next_wake;
		end
	end
	assign slave_wake = wake;

	always @* begin
		crystal_loss_live = 8'h00;
		crystal_loss_live[`PASB_BIT_CRYSTAL] = s2;
	end
	assign input_loss_live = {{(8-INPUTS){1'b0}}, loss2};
	assign pll_lock_freeze_live = {ret2, lol2};
	assign input_drift_live = {coarse2, fine2};

	pasb_notify #(.WIDTH(8)) u_crystal (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.live(crystal_loss_live),
		.sticky_wr(wr_crystal_sticky),
		.mask_wr(wr_crystal_mask),
		.wr_data(reg_wdata),
		.sticky(crystal_loss_sticky),
		.mask(crystal_mask)
	);

	pasb_notify #(.WIDTH(8)) u_pll (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.live(pll_lock_freeze_live),
		.sticky_wr(wr_pll_sticky),
		.mask_wr(wr_pll_mask),
		.wr_data(reg_wdata),
		.sticky(pll_lock_freeze_sticky),
		.mask(pll_mask)
	);

	pasb_notify #(.WIDTH(8)) u_loss (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.live(input_loss_live),
		.sticky_wr(wr_loss_sticky),
		.mask_wr(wr_loss_mask),
		.wr_data(reg_wdata),
		.sticky(input_loss_sticky),
		.mask(input_mask)
	);

	pasb_notify #(.WIDTH(8)) u_drift (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.live(input_drift_live),
		.sticky_wr(wr_drift_sticky),
		.mask_wr(wr_drift_mask),
		.wr_data(reg_wdata),
		.sticky(input_drift_sticky),
		.mask(drift_mask)
	);

	always @* begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			if (reg_addr == `PASB_OFS_PAGE) begin
				next_rdata = page_select;
			end else if (on_main && reg_addr == `PASB_OFS_WAKE) begin
				next_rdata = {1'h0, wake};
			end else if (on_main) begin
				next_rdata = page_word(reg_addr, crystal_loss_live, crystal_loss_sticky, crystal_mask,
					pll_lock_freeze_live, pll_lock_freeze_sticky, pll_mask);
			end else if (on_mon) begin
				next_rdata = page_word(reg_addr, input_loss_live, input_loss_sticky, input_mask,
					input_drift_live, input_drift_sticky, drift_mask);
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	// Read data holds until the next read
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

//--- pasb_host.sv
// Host model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module pasb_host (
	// Clock
	input wire logic clk_sys,
	// Register access
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_addr,
	output var logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 0;
		reg_rd = 0;
		reg_addr = 0;
		reg_wdata = 0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd = 1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 0;
		reg_addr = ~a;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

//--- pasb_bank_chk.sv
// Port assertions of the paged alarm status bank
`timescale 1ns/10ps
`default_nettype none
module pasb_bank_chk #(
	parameter INPUTS = 4,
	parameter PLLS = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] current_page,
	// Live status
	input wire logic crystal_input_missing,
	input wire logic [INPUTS-1:0] input_loss,
	input wire logic [INPUTS-1:0] fine_drift_live,
	input wire logic [INPUTS-1:0] coarse_drift_live,
	input wire logic [PLLS-1:0] pll_lock_loss,
	input wire logic [PLLS-1:0] retention_mode
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	wire pw = reg_wr && reg_addr == 8'hFF;
	wire r0 = reg_rd && current_page == 8'h00;
	wire r1 = reg_rd && current_page == 8'h01;
	wire [7:0] dr = {coarse_drift_live, fine_drift_live};
	wire [7:0] pl = {retention_mode, pll_lock_loss};
	a_page_write: assert property (pw |=> current_page == $past(reg_wdata))
		else $error("page write");
	a_page_hold: assert property (!pw |=> $stable(current_page))
		else $error("page hold");
	a_page_read: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == $past(current_page))
		else $error("page read");
	a_loss_live: assert property ($stable(input_loss)[*3] ##0 (r1 && reg_addr == 8'h02)
		|=> reg_rdata == $past(input_loss)) else $error("loss live");
	a_drift_live: assert property ($stable(dr)[*3] ##0 (r1 && reg_addr == 8'h06)
		|=> reg_rdata == $past(dr)) else $error("drift live");
	a_pll_live: assert property ($stable(pl)[*3] ##0 (r0 && reg_addr == 8'h06)
		|=> reg_rdata == $past(pl)) else $error("pll live");
	a_crystal_live: assert property ($stable(crystal_input_missing)[*3] ##0 (r0 && reg_addr == 8'h02)
		|=> reg_rdata[2] == $past(crystal_input_missing)) else $error("crystal live");
	a_other_page: assert property (reg_rd && current_page > 8'h01 && reg_addr != 8'hFF |=> reg_rdata == 8'h00)
		else $error("page not empty");
	c_page: cover property (pw);
	c_mon: cover property (r1 && reg_addr == 8'h07);
	c_main: cover property (r0 && reg_addr == 8'h07);
endmodule
bind pasb_bank pasb_bank_chk #(.INPUTS(INPUTS), .PLLS(PLLS)) chk (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.current_page(current_page),
	.crystal_input_missing(crystal_input_missing),
	.input_loss(input_loss),
	.fine_drift_live(fine_drift_live),
	.coarse_drift_live(coarse_drift_live),
	.pll_lock_loss(pll_lock_loss),
	.retention_mode(retention_mode)
);
`default_nettype wire

//--- pasb_bank_tb.sv
// Testbench of the paged alarm status bank
`timescale 1ns/10ps
`default_nettype none
module pasb_bank_tb;
	logic clk_sys = 0;
	logic arst_n = 0;
	logic crystal_input_missing = 0;
	logic reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, current_page, x;
	logic [3:0] input_loss = 0, fine_drift_live = 0, coarse_drift_live = 0, pll_lock_loss = 0, retention_mode = 0;
	logic [6:0] slave_wake;
	logic [7:0] pages [7] = '{8'h02, 8'h01, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
	int error_cnt = 0;
	int tests_run = 0;
	pasb_bank dut (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.crystal_input_missing(crystal_input_missing),
		.input_loss(input_loss),
		.fine_drift_live(fine_drift_live),
		.coarse_drift_live(coarse_drift_live),
		.pll_lock_loss(pll_lock_loss),
		.retention_mode(retention_mode),
		.slave_wake(slave_wake),
		.current_page(current_page)
	);
	pasb_host host (
		.clk_sys(clk_sys),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);
	always #2 clk_sys = ~clk_sys;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		host.rd(a, x);
		chk(x & m, exp);
	endtask
	task live(input logic [3:0] l, f, c, p, r, input logic xo);
		input_loss = l;
		fine_drift_live = f;
		coarse_drift_live = c;
		pll_lock_loss = p;
		retention_mode = r;
		crystal_input_missing = xo;
		repeat (4) @(negedge clk_sys);
	endtask
	task stop_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#40000;
		error_cnt++;
		stop_test;
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		arst_n = 1;
		chk({1'b0, slave_wake}, 8'h00);
		rc(8'hFF, 8'hFF, 8'h00);
		host.wr(8'hFF, 8'h00);
		host.wr(8'hE1, 8'h7F);
		foreach (pages[i]) begin
			host.wr(8'hFF, pages[i]);
			chk(current_page, pages[i]);
			rc(8'hFF, 8'hFF, pages[i]);
			rc(8'h02, 8'hFF, 8'h00);
		end
		chk({1'b0, slave_wake}, 8'h7F);
		host.wr(8'hFF, 8'h00);
		rc(8'h06, 8'h0F, 8'h00);
		host.wr(8'hFF, 8'h01);
		live(4'h5, 4'h3, 4'hA, 0, 0, 0);
		rc(8'h02, 8'hFF, 8'h05);
		rc(8'h06, 8'hFF, 8'hA3);
		rc(8'h03, 8'hFF, 8'h00);
		live(0, 0, 0, 0, 0, 0);
		host.wr(8'h04, 8'hFF);
		host.wr(8'h08, 8'hFF);
		rc(8'h08, 8'hFF, 8'hFF);
		live(4'h9, 4'hF, 4'hF, 0, 0, 0);
		live(0, 0, 0, 0, 0, 0);
		rc(8'h03, 8'h0F, 8'h09);
		host.wr(8'h03, 8'h01);
		rc(8'h03, 8'h0F, 8'h08);
		host.wr(8'h03, 8'h0F);
		rc(8'h03, 8'h0F, 8'h00);
		rc(8'h07, 8'hFF, 8'hFF);
		host.wr(8'h07, 8'hFF);
		rc(8'h07, 8'hFF, 8'h00);
		host.wr(8'hFF, 8'h00);
		host.wr(8'h04, 8'h04);
		host.wr(8'h08, 8'hFF);
		live(0, 0, 0, 4'h6, 4'h9, 1);
		rc(8'h06, 8'hFF, 8'h96);
		rc(8'h02, 8'h04, 8'h04);
		live(0, 0, 0, 0, 0, 0);
		rc(8'h03, 8'h04, 8'h04);
		rc(8'h07, 8'hFF, 8'h96);
		host.wr(8'h07, 8'hFF);
		host.wr(8'h03, 8'h04);
		rc(8'h07, 8'hFF, 8'h00);
		rc(8'h03, 8'h04, 8'h00);
		chk(current_page, 8'h00);
		host.wr(8'hFF, 8'h01);
		host.wr(8'h04, 8'hFF);
		arst_n = 0;
		repeat (2) @(negedge clk_sys);
		arst_n = 1;
		chk(current_page, 8'h00);
		host.wr(8'hFF, 8'h01);
		rc(8'h04, 8'hFF, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
